/* File: mordec_defs.svh */
// Constants for the move/option/return instruction decoder
`ifndef MORDEC_DEFS_SVH
`define MORDEC_DEFS_SVH

// ==========================================================
// Opcode encodings (14-bit words)
`define MORDEC_MOVE_MASK    14'h3F80
`define MORDEC_MOVE_MATCH   14'h0080
`define MORDEC_IDLE_MASK    14'h3F9F
`define MORDEC_IDLE_MATCH   14'h0000
`define MORDEC_FULL_MASK    14'h3FFF
`define MORDEC_OPTION_WORD  14'h0062
`define MORDEC_RETURN_WORD  14'h0009

// ==========================================================
// Field positions and reset values
`define MORDEC_FILE_MSB     6
`define MORDEC_IRQ_EN_BIT   7
`define MORDEC_PC_RESET     13'h0000
`define MORDEC_PC_STEP      13'h0001
`define MORDEC_ADDR_RESET   7'h00
`define MORDEC_ACC_RESET    8'h00
`define MORDEC_OPT_RESET    8'hFF
`define MORDEC_IRQ_RESET    8'h00

`endif

/* File: mordec_pkg.sv */
// Types for the move/option/return instruction decoder
package mordec_pkg;
    // Execution state, one-hot
    typedef enum logic [1:0] {
        MORDEC_EXEC   = 2'h1,
        MORDEC_RETURN = 2'h2
    } mordec_state_t;
endpackage

/* File: mordec_core.sv */
// Decode and execute logic for move-to-file, option load, no-op and interrupt return
`timescale 1ns/10ps
`include "mordec_defs.svh"
// Overview of operation
// - Move accumulator to file register 0..127, one cycle, flags untouched.
// - Legacy option opcode copies accumulator into option register in one cycle.
// - Interrupt return pops stack and loads popped top into program counter.
// - Interrupt return also sets global interrupt enable at control bit seven.
// - Interrupt return takes two instruction cycles for one program word.
module mordec_core (
    // Clock and reset
    input  wire logic        clock_i,
    input  wire logic        sys_rst_i,
    // Fetch port
    input  wire logic        instr_valid_i,
    input  wire logic [13:0] instr_i,
    // Working register and stack top from the core
    input  wire logic        acc_load_i,
    input  wire logic [7:0]  acc_data_i,
    input  wire logic [12:0] stack_top_i,
    // Fetch handshake back to the core
    output logic             ready_o,
    // Register file write port
    output logic             file_we_o,
    output logic [6:0]       file_addr_o,
    output logic [7:0]       file_data_o,
    // Option, stack and interrupt control
    output logic [7:0]       option_o,
    output logic             stack_pop_o,
    output logic [12:0]      pc_o,
    output logic [7:0]       irq_control_reg_o,
    output logic             global_irq_enable_o,
    // Word outside the decoded set
    output logic             unknown_o
);

    // ==========================================================
    // Decode helpers
    // Masked compare of one word against one opcode pattern
    function automatic logic match_f(input logic [13:0] w, input logic [13:0] m,
                                     input logic [13:0] v);
        match_f = ((w & m) == v);
    endfunction

    // ==========================================================
    // Internal state
    mordec_pkg::mordec_state_t state_reg;      // Execute or second return cycle
    logic [7:0]                acc_reg;        // Working register copy
    logic                      file_we_reg;    // File write strobe
    logic [6:0]                file_addr_reg;  // File address
    logic [7:0]                file_data_reg;  // File write data
    logic [7:0]                option_reg;     // Option register
    logic                      stack_pop_reg;  // Stack pop strobe
    logic [12:0]               pc_reg;         // Program counter
    logic [7:0]                irq_ctrl_reg;   // Interrupt control register
    logic                      unknown_reg;    // Word outside the decoded set

    // ==========================================================
    // Decode signals
    logic                      take;           // Word accepted at this edge
    logic                      is_mov;         // Move to file pattern
    logic                      is_opt;         // Option load word
    logic                      is_nop;         // No-operation pattern
    logic                      is_ret;         // Interrupt return word
    logic                      take_mov;
    logic                      take_opt;
    logic                      take_nop;
    logic                      take_ret;
    logic                      take_other;
    logic                      take_step;      // Accepted single-cycle word

    // ==========================================================
    // Fetch handshake
    // Words offered in the second return cycle are refused
    assign ready_o = (state_reg == mordec_pkg::MORDEC_EXEC);
    assign take    = instr_valid_i & ready_o;

    // ==========================================================
    // Opcode recognition
    // Fixed single-word opcodes compare all fourteen bits
    assign is_mov = match_f(instr_i, `MORDEC_MOVE_MASK, `MORDEC_MOVE_MATCH);
    assign is_opt = match_f(instr_i, `MORDEC_FULL_MASK, `MORDEC_OPTION_WORD);
    assign is_ret = match_f(instr_i, `MORDEC_FULL_MASK, `MORDEC_RETURN_WORD);
    // Both don't-care bits masked off
    assign is_nop = match_f(instr_i, `MORDEC_IDLE_MASK, `MORDEC_IDLE_MATCH);

    // Accepted word by kind, at most one high
    assign take_mov   = take & is_mov;
    assign take_opt   = take & is_opt;
    assign take_nop   = take & is_nop;
    assign take_ret   = take & is_ret;
    assign take_other = take & ~(is_mov | is_opt | is_nop | is_ret);
    // Every single-cycle word advances the program counter by one
    assign take_step  = take_mov | take_opt | take_nop | take_other;

    // ==========================================================
    // Output ports, all from flip-flops except ready
    assign file_we_o           = file_we_reg;
    assign file_addr_o         = file_addr_reg;
    assign file_data_o         = file_data_reg;
    assign option_o            = option_reg;
    assign stack_pop_o         = stack_pop_reg;
    assign pc_o                = pc_reg;
    assign irq_control_reg_o   = irq_ctrl_reg;
    assign global_irq_enable_o = irq_ctrl_reg[`MORDEC_IRQ_EN_BIT];
    assign unknown_o           = unknown_reg;

    // ==========================================================
    // Working register copy
    // Loaded by the core; a move in the same cycle sends the old value
    always_ff @(posedge clock_i) begin
        if (sys_rst_i) begin
            acc_reg <= `MORDEC_ACC_RESET;
        end else if (acc_load_i) begin
            acc_reg <= acc_data_i;
        end
    end

    // ==========================================================
    // Sequencer
    // Return holds a second cycle with ready low
    always_ff @(posedge clock_i) begin
        if (sys_rst_i) begin
            state_reg <= mordec_pkg::MORDEC_EXEC;
        end else begin
            case (state_reg)
                mordec_pkg::MORDEC_EXEC: begin
                    if (take_ret) begin
                        state_reg <= mordec_pkg::MORDEC_RETURN;
                    end
                end
                mordec_pkg::MORDEC_RETURN: begin
                    state_reg <= mordec_pkg::MORDEC_EXEC;
                end
                default: begin
                    state_reg <= mordec_pkg::MORDEC_EXEC;
                end
            endcase
        end
    end

    // ==========================================================
    // File write strobe
    // One-cycle pulse; no status flag is touched
    always_ff @(posedge clock_i) begin
        if (sys_rst_i) begin
            file_we_reg <= 1'b0;
        end else begin
            file_we_reg <= take_mov;
        end
    end

    // ==========================================================
    // File address and data
    // Held after the strobe until the next move
    always_ff @(posedge clock_i) begin
        if (sys_rst_i) begin
            file_addr_reg <= `MORDEC_ADDR_RESET;
            file_data_reg <= `MORDEC_ACC_RESET;
        end else if (take_mov) begin
            file_addr_reg <= instr_i[`MORDEC_FILE_MSB:0];
            file_data_reg <= acc_reg;
        end
    end

    // ==========================================================
    // Option register
    // Legacy load: working register copied in one cycle
    always_ff @(posedge clock_i) begin
        if (sys_rst_i) begin
            option_reg <= `MORDEC_OPT_RESET;
        end else if (take_opt) begin
            option_reg <= acc_reg;
        end
    end

    // ==========================================================
    // Stack pop strobe
    // One pulse for each accepted return
    always_ff @(posedge clock_i) begin
        if (sys_rst_i) begin
            stack_pop_reg <= 1'b0;
        end else begin
            stack_pop_reg <= take_ret;
        end
    end

    // ==========================================================
    // Program counter
    // Return loads the popped top; other words step by one
    always_ff @(posedge clock_i) begin
        if (sys_rst_i) begin
            pc_reg <= `MORDEC_PC_RESET;
        end else if (take_ret) begin
            pc_reg <= stack_top_i;
        end else if (take_step) begin
            pc_reg <= pc_reg + `MORDEC_PC_STEP;
        end
    end

    // ==========================================================
    // Interrupt control
    // Return sets the global enable; only reset clears a bit here
    always_ff @(posedge clock_i) begin
        if (sys_rst_i) begin
            irq_ctrl_reg <= `MORDEC_IRQ_RESET;
        end else if (take_ret) begin
            irq_ctrl_reg[`MORDEC_IRQ_EN_BIT] <= 1'b1;
        end
    end

    // ==========================================================
    // Unknown word flag
    // Pulses for words outside this decoder's set
    always_ff @(posedge clock_i) begin
        if (sys_rst_i) begin
            unknown_reg <= 1'b0;
        end else begin
            unknown_reg <= take_other;
        end
    end

endmodule // mordec_core

/* File: mordec_checker.sv */
// Concurrent checks on the decoder ports
`timescale 1ns/10ps
`include "mordec_defs.svh"
module mordec_checker (
    input wire logic        clock_i,
    input wire logic        sys_rst_i,
    input wire logic        instr_valid_i,
    input wire logic [13:0] instr_i,
    input wire logic [12:0] stack_top_i,
    input wire logic        ready_o,
    input wire logic        file_we_o,
    input wire logic [6:0]  file_addr_o,
    input wire logic [7:0]  option_o,
    input wire logic        stack_pop_o,
    input wire logic [12:0] pc_o,
    input wire logic        global_irq_enable_o
);
    default clocking @(posedge clock_i); endclocking
    default disable iff (sys_rst_i);
    // ==========================================
    // Accepted words by kind
    wire       tk  = instr_valid_i & ready_o;
    wire       mv  = tk & ((instr_i & `MORDEC_MOVE_MASK) == `MORDEC_MOVE_MATCH);
    wire       op  = tk & (instr_i == `MORDEC_OPTION_WORD);
    wire       rt  = tk & (instr_i == `MORDEC_RETURN_WORD);
    wire       np  = tk & ((instr_i & `MORDEC_IDLE_MASK) == `MORDEC_IDLE_MATCH);
    wire [6:0] fld = instr_i[`MORDEC_FILE_MSB:0];
    // Busy cycle, then ready again
    sequence ret_gap;
        !ready_o ##1 ready_o;
    endsequence
    // Word offered while the decoder is busy
    sequence busy_offer;
        instr_valid_i && !ready_o;
    endsequence
    chk_move_addr: assert property (mv |=> file_we_o && file_addr_o == $past(fld))
        else $error("move addr");
    chk_we_cause: assert property (file_we_o |-> $past(mv)) else $error("stray we");
    chk_opt_hold: assert property (!op |=> $stable(option_o)) else $error("opt");
    chk_ret_pc: assert property (rt |=> pc_o == $past(stack_top_i) && stack_pop_o)
        else $error("ret pc");
    chk_pop_cause: assert property (stack_pop_o |-> $past(rt)) else $error("pop");
    chk_ret_gie: assert property (rt |=> global_irq_enable_o) else $error("gie");
    chk_ret_gap: assert property (rt |=> ret_gap) else $error("ret len");
    chk_nop_pc: assert property (np |=> pc_o == $past(pc_o) + 13'h1 && !file_we_o)
        else $error("nop");
    chk_busy_refuse: assert property (busy_offer |=> !file_we_o && !stack_pop_o)
        else $error("busy take");
    chk_gie_keep: assert property (global_irq_enable_o |=> global_irq_enable_o)
        else $error("gie lost");
endmodule // mordec_checker

bind mordec_core mordec_checker u_chk (.clock_i, .sys_rst_i, .instr_valid_i, .instr_i,
    .stack_top_i, .ready_o, .file_we_o, .file_addr_o, .option_o, .stack_pop_o, .pc_o,
    .global_irq_enable_o);

/* File: mordec_stack_model.sv */
// Hardware stack model feeding return addresses
`timescale 1ns/10ps
module mordec_stack_model (
    input  wire logic        clock_i,
    input  wire logic        sys_rst_i,
    input  wire logic        stack_pop_i,
    output logic      [12:0] stack_top_o
);
    logic [2:0] ptr_reg;
    // Each pop exposes the next entry; reset returns to the first
    always_ff @(posedge clock_i) begin
        if (sys_rst_i) begin
            ptr_reg <= 3'h0;
        end else if (stack_pop_i) begin
            ptr_reg <= ptr_reg + 3'h1;
        end
    end
    assign stack_top_o = 13'hA00 + 13'(ptr_reg);
endmodule // mordec_stack_model

/* File: mordec_core_test.sv */
// Self-checking bench for the decoder
`timescale 1ns/10ps
module mordec_core_test;
    logic        clock_i = 0, sys_rst_i = 1, instr_valid_i = 0, acc_load_i = 0;
    logic [13:0] instr_i = 0;
    logic [7:0]  acc_data_i = 0, file_data_o, option_o, irq_control_reg_o;
    logic [12:0] stack_top_i, pc_o;
    logic [6:0]  file_addr_o, f;
    logic        ready_o, file_we_o, stack_pop_o, global_irq_enable_o, unknown_o;
    logic [14:0] q[$];
    int          error_cnt = 0, cmp_count = 0, cyc = 0, seed = 32'hC698, i;
    mordec_core u_dut (.clock_i, .sys_rst_i, .instr_valid_i, .instr_i, .acc_load_i,
        .acc_data_i, .stack_top_i, .ready_o, .file_we_o, .file_addr_o, .file_data_o,
        .option_o, .stack_pop_o, .pc_o, .irq_control_reg_o, .global_irq_enable_o,
        .unknown_o);
    mordec_stack_model u_stk (.clock_i, .sys_rst_i, .stack_pop_i(stack_pop_o),
        .stack_top_o(stack_top_i));
    task chk(input string n, input logic [14:0] s, input logic [14:0] e);
        cmp_count++;
        if (s !== e) begin
            error_cnt++;
            $display("CHECK FAILED %s exp %h got %h", n, e, s);
        end
    endtask
    task step(input logic v, input logic [13:0] w, input logic l);
        instr_valid_i = v;
        instr_i = w;
        acc_load_i = l;
        @(posedge clock_i);
        #2;
    endtask
    task complete_run;
        $display("compares %0d errors %0d", cmp_count, error_cnt);
        if (error_cnt == 0 && cmp_count > 0) $display("[ PASS ]");
        else $display("[ FAIL ]");
        $finish;
    endtask
    initial forever #12.5 clock_i = ~clock_i;
    // Result watcher and hang limit, sampled mid-cycle where outputs are settled
    always @(negedge clock_i) begin
        cyc++;
        if (cyc > 500) begin
            error_cnt++;
            complete_run;
        end else begin
            if (file_we_o) chk("file", {file_addr_o, file_data_o}, q.pop_front());
            if (stack_pop_o) chk("ret", {1'b0, global_irq_enable_o, pc_o}, q.pop_front());
        end
    end
    // Main sequence
    initial begin
        repeat (4) @(posedge clock_i);
        #2;
        sys_rst_i = 0;
        for (i = 0; i < 6; i++) begin
            acc_data_i = 8'($random(seed));
            step(0, 0, 1);
            f = (i == 1) ? 7'h7F : 7'(i * 37);
            q.push_back({f, acc_data_i});
            step(1, 14'h0080 | 14'(f), 0);
        end
        $display("move done");
        acc_data_i = 8'($random(seed));
        step(0, 0, 1);
        step(1, 14'h0062, 0);
        chk("opt", {7'h0, option_o}, {7'h0, acc_data_i});
        for (i = 0; i < 4; i++) step(1, 14'(i << 5), 0);
        chk("pc", {2'h0, pc_o}, 15'h000B);
        step(1, 14'h3FFF, 0);
        chk("unknown", {14'h0, unknown_o}, 15'h0001);
        chk("pc step", {2'h0, pc_o}, 15'h000C);
        chk("irq idle", {7'h0, irq_control_reg_o}, 15'h0000);
        $display("option nop done");
        for (i = 0; i < 2; i++) begin
            q.push_back({2'h1, 13'hA00 + 13'(i)});
            step(1, 14'h0009, 0);
            chk("rdy", {14'h0, ready_o}, 15'h0);
            step(1, 14'h0085, 0);
            step(0, 0, 0);
        end
        chk("left", 15'(q.size()), 15'h0);
        chk("irq reg", {7'h0, irq_control_reg_o}, 15'h0080);
        $display("return done");
        sys_rst_i = 1;
        step(0, 0, 0);
        chk("rst opt", {7'h0, option_o}, 15'h00FF);
        chk("rst pc", {2'h0, pc_o}, 15'h0000);
        chk("rst rdy", {12'h0, ready_o, global_irq_enable_o, unknown_o}, 15'h0004);
        sys_rst_i = 0;
        q.push_back({2'h1, 13'hA00});
        step(1, 14'h0009, 0);
        chk("rst busy", {14'h0, ready_o}, 15'h0);
        step(0, 0, 0);
        chk("rst irq", {7'h0, irq_control_reg_o}, 15'h0080);
        chk("rst left", 15'(q.size()), 15'h0);
        $display("reset return done");
        complete_run;
    end
endmodule // mordec_core_test
